// file: pkg/cpc_cfg.svh
// Constants for the card interface pin and clock control block
// Assumes inclusion by bare name from design and testbench files
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define CPC_OFF_PIN_MODE 4'h0
`define CPC_OFF_CLK_CTL 4'h4
`define CPC_OFF_STATUS 4'h8

// ==========================================================================
// Reset values and writable masks
`define CPC_PIN_MODE_RST 8'h00
`define CPC_CLK_CTL_RST 8'h00
`define CPC_PIN_MODE_WMASK 8'hc3
`define CPC_CLK_CTL_WMASK 8'h87

// ==========================================================================
// Field positions
`define CPC_BIT_CARD_COUNT 7
`define CPC_BIT_CARD_SEL 6
`define CPC_BIT_DIR_EN 1
`define CPC_BIT_PIN_EN 0
`define CPC_BIT_CLK_ON 7
`define CPC_DIV_MSB 2
`define CPC_DIV_LSB 0

// ==========================================================================
// Divider codes and half periods in system clocks
`define CPC_DIV_100 3'h0
`define CPC_DIV_8 3'h1
`define CPC_DIV_4 3'h2
`define CPC_DIV_2 3'h3
`define CPC_DIV_1 3'h4
`define CPC_HALF_100 6'h32
`define CPC_HALF_8 6'h04
`define CPC_HALF_4 6'h02
`define CPC_HALF_2 6'h01

`endif

// file: pkg/cpc_pkg.sv
// Types for the card interface pin and clock control block
// Assumes cpc_cfg.svh is on the include path
package cpc_pkg;

  // ========================================================================
  // Transfer clock divider
  typedef enum logic [1:0] {
    CPC_PH_IDLE = 2'b00,
    CPC_PH_LOW = 2'b01,
    CPC_PH_HIGH = 2'b10,
    CPC_PH_FULL = 2'b11
  } cpc_phase_t;

  typedef struct packed {
    cpc_phase_t phase;
    logic [2:0] sel;
    logic [5:0] cnt;
    logic level;
    logic tick;
  } cpc_div_state_t;

  // ========================================================================
  // Card pin group: output value and enable per pin, enable only for the clock pin
  typedef struct packed {
    logic clk_oe;
    logic cmd_out;
    logic cmd_oe;
    logic dat_out;
    logic dat_oe;
    logic cs_a_out;
    logic cs_a_oe;
    logic cs_b_out;
    logic cs_b_oe;
  } cpc_pins_t;

  // ========================================================================
  // Top state
  typedef struct packed {
    logic [7:0] pin_mode;
    logic [7:0] clk_ctl;
    logic ack;
    logic [7:0] dat;
    cpc_pins_t pins;
  } cpc_state_t;

endpackage

// file: src/cpc_clkdiv.sv
// Transfer clock divider with glitch-free start, stop and rate change in divided modes; leaving full rate can trim the last high pulse
// Assumes one system clock; run and sel come from registers
`timescale 1ns/1ps
`include "cpc_cfg.svh"

module cpc_clkdiv
  import cpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic [2:0] sel,
  // Clock out and status
  output logic clk_out,
  output logic tick,
  output logic busy,
  output logic [2:0] active_sel
);

  // ========================================================================
  // Helpers
  function automatic logic [5:0] half_count(input logic [2:0] code);
    case (code)
      `CPC_DIV_100: half_count = `CPC_HALF_100;
      `CPC_DIV_8: half_count = `CPC_HALF_8;
      `CPC_DIV_4: half_count = `CPC_HALF_4;
      default: half_count = `CPC_HALF_2;
    endcase
  endfunction

  function automatic logic sel_ok(input logic [2:0] code);
    sel_ok = (code <= `CPC_DIV_1);
  endfunction

  // ========================================================================
  // Divider state
  cpc_div_state_t div_reg;
  cpc_div_state_t div_next;
  logic [2:0] keep_sel;
  logic end_half;

  always_comb begin
    div_next = div_reg;
    div_next.tick = 1'b0;
    // Prohibited codes leave the running rate unchanged
    keep_sel = sel_ok(sel) ? sel : div_reg.sel;
    end_half = (div_reg.cnt == half_count(div_reg.sel) - 6'h01);
    case (div_reg.phase)
      CPC_PH_IDLE: begin
        div_next.level = 1'b0;
        div_next.cnt = 6'h00;
        if (run && sel_ok(sel)) begin
          div_next.sel = sel;
          div_next.phase = (sel == `CPC_DIV_1) ? CPC_PH_FULL : CPC_PH_LOW;
        end
      end
      CPC_PH_LOW: begin
        if (end_half) begin
          div_next.level = 1'b1;
          div_next.tick = 1'b1;
          div_next.cnt = 6'h00;
          div_next.phase = CPC_PH_HIGH;
        end else begin
          div_next.cnt = div_reg.cnt + 6'h01;
        end
      end
      CPC_PH_HIGH: begin
        if (end_half) begin
          // In divided modes only a falling edge may stop or re-rate the clock
          div_next.level = 1'b0;
          div_next.cnt = 6'h00;
          div_next.sel = keep_sel;
          if (!run) begin
            div_next.phase = CPC_PH_IDLE;
          end else if (keep_sel == `CPC_DIV_1) begin
            div_next.phase = CPC_PH_FULL;
          end else begin
            div_next.phase = CPC_PH_LOW;
          end
        end else begin
          div_next.cnt = div_reg.cnt + 6'h01;
        end
      end
      CPC_PH_FULL: begin
        div_next.tick = run;
        if (!run) begin
          div_next.phase = CPC_PH_IDLE;
        end else if (keep_sel != `CPC_DIV_1) begin
          div_next.sel = keep_sel;
          div_next.phase = CPC_PH_LOW;
        end
      end
      default: div_next.phase = CPC_PH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // Full rate gates the system clock itself; exit from it can trim the last high pulse
  assign clk_out = (div_reg.phase == CPC_PH_FULL) ? ref_clk : div_reg.level;
  assign tick = div_reg.tick;
  assign busy = (div_reg.phase != CPC_PH_IDLE);
  assign active_sel = div_reg.sel;

  // ========================================================================
  // Checks
  half_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (div_reg.phase == CPC_PH_LOW || div_reg.phase == CPC_PH_HIGH) |-> div_reg.cnt < half_count(div_reg.sel))
    else $error("divider count beyond half period");
  fast_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(div_reg.level) && div_reg.sel == `CPC_DIV_2) |=> !div_reg.level)
    else $error("div2 high phase not one cycle");
  slow_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(div_reg.level) && div_reg.sel == `CPC_DIV_4) |-> div_reg.level[*2] ##1 !div_reg.level)
    else $error("div4 high phase not two cycles");

endmodule // cpc_clkdiv

// file: src/cpc_top.sv
// Pin mode and transfer clock control for a memory card interface
// Assumes classic Wishbone master on ref_clk and a card engine supplying line data
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "cpc_cfg.svh"

module cpc_top
  import cpc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Card engine side
  input wire logic spi_mode,
  input wire logic engine_cs_b,
  input wire logic engine_cmd_out,
  input wire logic engine_cmd_oe,
  input wire logic engine_dat_out,
  input wire logic engine_dat_oe,
  output logic engine_cmd_in,
  output logic engine_dat_in,
  output logic engine_clk_tick,
  // Card clock pin
  output logic card_clock_pin_out,
  output logic card_clock_pin_oe,
  // Card command pin, transmit in SPI mode
  input wire logic card_command_pin_in,
  output logic card_command_pin_out,
  output logic card_command_pin_oe,
  // Card data pin, receive in SPI mode
  input wire logic card_data_pin_in,
  output logic card_data_pin_out,
  output logic card_data_pin_oe,
  // Chip select A or data direction
  output logic chip_select_a_pin_out,
  output logic chip_select_a_pin_oe,
  // Chip select B or command direction
  output logic chip_select_b_pin_out,
  output logic chip_select_b_pin_oe
);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] data,
                                              input logic [7:0] mask);
    masked_write = (old & ~mask) | (data & mask);
  endfunction

  // ==========================================================================
  // State
  cpc_state_t s_reg;
  cpc_state_t s_next;

  logic [3:0] word_adr;
  logic bus_req;
  logic wr_lane0;
  logic spi_card_count;
  logic card_select_choice;
  logic direction_out_en;
  logic pin_function_en;
  logic clock_output_on;
  logic [2:0] divider_sel;
  logic div_clk;
  logic div_tick;
  logic div_busy;
  logic [2:0] div_active_sel;
  logic [7:0] status_byte;

  assign word_adr = {wb_adr_i[3:2], 2'b00};
  assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

  assign spi_card_count = s_reg.pin_mode[`CPC_BIT_CARD_COUNT];
  assign card_select_choice = s_reg.pin_mode[`CPC_BIT_CARD_SEL];
  assign direction_out_en = s_reg.pin_mode[`CPC_BIT_DIR_EN];
  assign pin_function_en = s_reg.pin_mode[`CPC_BIT_PIN_EN];
  assign clock_output_on = s_reg.clk_ctl[`CPC_BIT_CLK_ON];
  assign divider_sel = s_reg.clk_ctl[`CPC_DIV_MSB:`CPC_DIV_LSB];
  assign status_byte = {4'h0, div_active_sel, div_busy};

  // ==========================================================================
  // Transfer clock divider
  // The clock starts only with the pins enabled and, once they are off, ends after its high phase or at once at full rate, so a stray bit 7 stays off the card
  cpc_clkdiv u_clkdiv (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(clock_output_on && pin_function_en),
    .sel(divider_sel),
    .clk_out(div_clk),
    .tick(div_tick),
    .busy(div_busy),
    .active_sel(div_active_sel)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    // Register bus: one wait state, ack dropped the cycle after
    s_next.ack = bus_req;
    s_next.dat = 8'h00;
    if (bus_req && !wb_we_i) begin
      case (word_adr)
        `CPC_OFF_PIN_MODE: s_next.dat = s_reg.pin_mode;
        `CPC_OFF_CLK_CTL: s_next.dat = s_reg.clk_ctl;
        `CPC_OFF_STATUS: s_next.dat = status_byte;
        default: s_next.dat = 8'h00;
      endcase
    end
    if (wr_lane0) begin
      case (word_adr)
        `CPC_OFF_PIN_MODE: s_next.pin_mode = masked_write(s_reg.pin_mode, wb_dat_i[7:0], `CPC_PIN_MODE_WMASK);
        `CPC_OFF_CLK_CTL: s_next.clk_ctl = masked_write(s_reg.clk_ctl, wb_dat_i[7:0], `CPC_CLK_CTL_WMASK);
        default: s_next.dat = 8'h00;
      endcase
    end

    // Pin drive, all enables off while the pin function is off
    s_next.pins = '0;
    s_next.pins.cs_a_out = 1'b1;
    s_next.pins.cs_b_out = 1'b1;
    s_next.pins.cmd_out = 1'b1;
    s_next.pins.dat_out = 1'b1;
    if (pin_function_en) begin
      s_next.pins.clk_oe = 1'b1;
      if (spi_mode) begin
        s_next.pins.cmd_out = engine_cmd_out;
        s_next.pins.cmd_oe = 1'b1;
        s_next.pins.cs_a_oe = 1'b1;
        if (!spi_card_count) begin
          s_next.pins.cs_a_out = engine_cs_b;
        end else begin
          s_next.pins.cs_b_oe = 1'b1;
          s_next.pins.cs_a_out = card_select_choice ? 1'b1 : engine_cs_b;
          s_next.pins.cs_b_out = card_select_choice ? engine_cs_b : 1'b1;
        end
      end else begin
        s_next.pins.cmd_out = engine_cmd_out;
        s_next.pins.cmd_oe = engine_cmd_oe;
        s_next.pins.dat_out = engine_dat_out;
        s_next.pins.dat_oe = engine_dat_oe;
        // Indicators show high while the controller drives the line
        s_next.pins.cs_a_out = engine_dat_oe;
        s_next.pins.cs_b_out = engine_cmd_oe;
        s_next.pins.cs_a_oe = direction_out_en;
        s_next.pins.cs_b_oe = direction_out_en;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.pin_mode <= `CPC_PIN_MODE_RST;
      s_reg.clk_ctl <= `CPC_CLK_CTL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = {24'h000000, s_reg.dat};
  assign card_clock_pin_out = div_clk;
  assign card_clock_pin_oe = s_reg.pins.clk_oe;
  assign card_command_pin_out = s_reg.pins.cmd_out;
  assign card_command_pin_oe = s_reg.pins.cmd_oe;
  assign card_data_pin_out = s_reg.pins.dat_out;
  assign card_data_pin_oe = s_reg.pins.dat_oe;
  assign chip_select_a_pin_out = s_reg.pins.cs_a_out;
  assign chip_select_a_pin_oe = s_reg.pins.cs_a_oe;
  assign chip_select_b_pin_out = s_reg.pins.cs_b_out;
  assign chip_select_b_pin_oe = s_reg.pins.cs_b_oe;
  // Disabled inputs read idle high so the engine never sees a floating start bit
  assign engine_cmd_in = pin_function_en ? card_command_pin_in : 1'b1;
  assign engine_dat_in = pin_function_en ? card_data_pin_in : 1'b1;
  assign engine_clk_tick = div_tick;

  // ==========================================================================
  // Checks
  bus_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");

  reserved_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000 && s_reg.pin_mode[5:2] == 4'h0
    && s_reg.clk_ctl[6:3] == 4'h0))
    else $error("reserved bits not zero");

  mode_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_lane0 && word_adr == `CPC_OFF_PIN_MODE) |=>
    s_reg.pin_mode == ($past(wb_dat_i[7:0]) & `CPC_PIN_MODE_WMASK))
    else $error("pin mode write wrong");

  pins_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pin_function_en |=> !(card_clock_pin_oe || card_command_pin_oe || card_data_pin_oe
    || chip_select_a_pin_oe || chip_select_b_pin_oe))
    else $error("pin driven while pin function off");

  single_card_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (spi_mode && !spi_card_count) |=> !chip_select_b_pin_oe)
    else $error("chip select B driven with one card");

  select_b_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (spi_mode && pin_function_en && spi_card_count && card_select_choice) |=>
    (chip_select_a_pin_out && chip_select_b_pin_out == $past(engine_cs_b)))
    else $error("card B select wrong");

  direction_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!spi_mode && !direction_out_en) |=> !(chip_select_a_pin_oe || chip_select_b_pin_oe))
    else $error("direction output without enable");

  clock_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!clock_output_on && !div_busy) |-> !card_clock_pin_out)
    else $error("card clock not low when off");

  clock_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(clock_output_on) && pin_function_en && divider_sel == `CPC_DIV_2 && !div_busy)
    |=> div_busy ##1 card_clock_pin_out)
    else $error("div2 clock did not start");

  stop_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(div_busy) |-> !card_clock_pin_out)
    else $error("clock stopped while high");

  select_a_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (spi_mode && pin_function_en && spi_card_count && !card_select_choice) |=>
    (chip_select_b_pin_out && chip_select_a_pin_out == $past(engine_cs_b)))
    else $error("card A select wrong");

  single_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (spi_mode && pin_function_en && !spi_card_count) |=>
    (chip_select_a_pin_oe && chip_select_a_pin_out == $past(engine_cs_b)))
    else $error("single card select wrong");

  direction_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!spi_mode && pin_function_en && direction_out_en) |=>
    (chip_select_a_pin_oe && chip_select_b_pin_oe && chip_select_a_pin_out == $past(engine_dat_oe)
    && chip_select_b_pin_out == $past(engine_cmd_oe)))
    else $error("direction indicator wrong");

  mmc_lines_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!spi_mode && pin_function_en) |=>
    (card_command_pin_oe == $past(engine_cmd_oe) && card_data_pin_oe == $past(engine_dat_oe)
    && card_clock_pin_oe))
    else $error("card line drive wrong");

  inputs_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pin_function_en |-> (engine_cmd_in && engine_dat_in))
    else $error("disabled input not idle");

  clock_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_lane0 && word_adr == `CPC_OFF_CLK_CTL) |=>
    s_reg.clk_ctl == ($past(wb_dat_i[7:0]) & `CPC_CLK_CTL_WMASK))
    else $error("clock control write wrong");

  lane_guard_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (bus_req && wb_we_i && !wb_sel_i[0]) |=> ($stable(s_reg.pin_mode) && $stable(s_reg.clk_ctl)))
    else $error("write without byte lane");

  // Stop waits for the high phase to end, so allow one full slow period
  pins_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(pin_function_en) |-> ##[1:110] (!div_busy || pin_function_en))
    else $error("clock runs with pins off");

  // ==========================================================================
  // Coverage
  two_cards_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    spi_mode && pin_function_en && spi_card_count && card_select_choice);
  mmc_dir_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    !spi_mode && pin_function_en && direction_out_en && engine_cmd_oe);
  slow_clock_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    div_busy && div_active_sel == `CPC_DIV_100 && engine_clk_tick);
  rate_change_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    div_busy && $changed(div_active_sel));
  full_rate_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    div_busy && div_active_sel == `CPC_DIV_1);

endmodule // cpc_top

// file: tb/cpc_card_model.sv
// Card side model: pulled-up command and data lines, clock edge timing
// Assumes 1 ns time unit and host pins split into value and enable
`timescale 1ns/1ps
module cpc_card_model (
  // Host pins
  input wire logic clk_pin,
  input wire logic clk_oe,
  input wire logic cmd_out,
  input wire logic cmd_oe,
  input wire logic dat_out,
  input wire logic dat_oe,
  // Card drive from bench; the card is always seated, insertion is firmware's job
  input wire logic card_drv,
  input wire logic card_val,
  // Wire levels and clock timing
  output logic cmd_line,
  output logic dat_line,
  output logic [31:0] period_ns,
  output logic [31:0] high_ns,
  output logic [31:0] rise_cnt
);
  time t_rise = 0;
  logic clk_line;
  // ==========================================================================
  // Wires
  // Released clock pin sits low on the card's pull-down
  assign clk_line = clk_oe & clk_pin;
  // Pull-ups: a released line reads high unless the card drives it, never its stale value
  assign cmd_line = cmd_oe ? cmd_out : (card_drv ? card_val : 1'b1);
  assign dat_line = dat_oe ? dat_out : (card_drv ? ~card_val : 1'b1);
  // ==========================================================================
  // Clock timing
  initial begin
    rise_cnt = 0;
    period_ns = 0;
    high_ns = 0;
  end
  always @(posedge clk_line) begin
    period_ns = 32'($time - t_rise);
    t_rise = $time;
    rise_cnt = rise_cnt + 1;
  end
  always @(negedge clk_line) begin
    high_ns = 32'($time - t_rise);
  end
endmodule // cpc_card_model

// file: tb/cpc_top_test.sv
// Testbench for the pin mode and transfer clock control block
// Assumes cpc_cfg.svh on the include path and a 10 MHz ref_clk
`timescale 1ns/1ps
`include "cpc_cfg.svh"
module cpc_top_test;
  logic ref_clk = 0, rst_b = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic wb_ack_o;
  logic spi_mode = 0, engine_cs_b = 1, engine_cmd_out = 1, engine_cmd_oe = 0;
  logic engine_dat_out = 1, engine_dat_oe = 0, card_drv = 0, card_val = 0;
  logic engine_cmd_in, engine_dat_in, engine_clk_tick;
  logic card_clock_pin_out, card_clock_pin_oe, card_command_pin_in, card_command_pin_out, card_command_pin_oe;
  logic card_data_pin_in, card_data_pin_out, card_data_pin_oe;
  logic chip_select_a_pin_out, chip_select_a_pin_oe, chip_select_b_pin_out, chip_select_b_pin_oe;
  logic [31:0] period_ns, high_ns, rise_cnt;
  logic [31:0] exp_q[$];
  int error_cnt = 0, check_count = 0;
  int divs[5] = '{100, 8, 4, 2, 1};

  cpc_top i_dut (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .spi_mode, .engine_cs_b, .engine_cmd_out, .engine_cmd_oe, .engine_dat_out,
    .engine_dat_oe, .engine_cmd_in, .engine_dat_in, .engine_clk_tick, .card_clock_pin_out,
    .card_clock_pin_oe, .card_command_pin_in, .card_command_pin_out, .card_command_pin_oe,
    .card_data_pin_in, .card_data_pin_out, .card_data_pin_oe, .chip_select_a_pin_out,
    .chip_select_a_pin_oe, .chip_select_b_pin_out, .chip_select_b_pin_oe);

  cpc_card_model i_card (.clk_pin(card_clock_pin_out), .clk_oe(card_clock_pin_oe),
    .cmd_out(card_command_pin_out), .cmd_oe(card_command_pin_oe), .dat_out(card_data_pin_out),
    .dat_oe(card_data_pin_oe), .card_drv, .card_val, .cmd_line(card_command_pin_in),
    .dat_line(card_data_pin_in), .period_ns, .high_ns, .rise_cnt);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Read answers are matched against the oldest noted expectation
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) chk(1, 0, "unexpected read ack");
      else chk(wb_dat_o, exp_q.pop_front(), "read data");
    end
  end

  // ==========================================================================
  // Bus tasks
  task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d, input logic [3:0] sel = 4'h1);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'($urandom), d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(32'(n), 32'h2, "ack latency");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, adr, 8'h00);
  endtask

  // ==========================================================================
  // Scenario tasks
  task automatic pins(input logic [7:0] pm, input logic spi);
    logic cnt, cs, dir, pen;
    {cnt, cs} = pm[7:6];
    dir = pm[1];
    pen = pm[0];
    wb(1'b1, `CPC_OFF_PIN_MODE, pm | (8'($urandom) & 8'h3c));
    rd(`CPC_OFF_PIN_MODE, pm);
    spi_mode <= spi;
    {engine_cs_b, engine_cmd_out, engine_cmd_oe, engine_dat_out, engine_dat_oe, card_drv, card_val} <= 7'($urandom);
    repeat (3) @(posedge ref_clk);
    chk(card_clock_pin_oe, pen, "clock oe");
    chk(engine_dat_in, pen ? card_data_pin_in : 1'b1, "data in");
    chk(engine_cmd_in, pen ? card_command_pin_in : 1'b1, "cmd in");
    if (spi) begin
      chk(card_data_pin_oe, 0, "spi data oe");
      chk(chip_select_a_pin_oe, pen, "cs a oe");
      chk(chip_select_b_pin_oe, pen & cnt, "cs b oe");
      if (pen) chk(chip_select_a_pin_out, (cnt & cs) ? 1'b1 : engine_cs_b, "cs a");
      if (pen & cnt) chk(chip_select_b_pin_out, cs ? engine_cs_b : 1'b1, "cs b");
    end else begin
      chk(chip_select_a_pin_oe, pen & dir, "data dir oe");
      chk(chip_select_b_pin_oe, pen & dir, "cmd dir oe");
      if (pen & dir) chk({chip_select_a_pin_out, chip_select_b_pin_out}, {engine_dat_oe, engine_cmd_oe}, "dir");
      chk(card_command_pin_oe, pen & engine_cmd_oe, "cmd oe");
      if (pen) chk(card_command_pin_out, engine_cmd_out, "cmd out");
      chk(card_data_pin_oe, pen & engine_dat_oe, "dat oe");
      if (pen) chk(card_data_pin_out, engine_dat_out, "dat out");
    end
  endtask

  // Measure only after a few rises: the first one may follow the old rate
  task automatic clk_rate(input logic [2:0] code, input int div);
    int n;
    int t;
    logic [31:0] r0;
    n = 0;
    t = 0;
    wb(1'b1, `CPC_OFF_CLK_CTL, {1'b1, 4'($urandom), code});
    r0 = rise_cnt;
    while (rise_cnt - r0 < 3 && n < 2000) begin
      @(posedge ref_clk);
      n++;
      t += engine_clk_tick;
    end
    chk(period_ns, 32'(div * 100), "clock period");
    chk(high_ns, 32'(div * 50), "clock high time");
    // At full rate the pin edge races the bench clock, so ticks are counted only when divided
    if (div > 1) chk(32'(t), rise_cnt - r0, "clock ticks");
  endtask

  task automatic quiet();
    logic [31:0] r0;
    repeat (60) @(posedge ref_clk);
    r0 = rise_cnt;
    repeat (100) @(posedge ref_clk);
    chk(rise_cnt, r0, "clock still running");
    chk(card_clock_pin_out, 0, "clock level");
    chk(engine_clk_tick, 0, "tick while stopped");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(35089));
    repeat (12) @(posedge ref_clk);
    chk({card_clock_pin_oe, card_command_pin_oe, card_data_pin_oe, chip_select_a_pin_oe, chip_select_b_pin_oe}, 0,
      "reset enables");
    rst_b <= 1'b1;
    rd(`CPC_OFF_PIN_MODE, `CPC_PIN_MODE_RST);
    rd(`CPC_OFF_CLK_CTL, `CPC_CLK_CTL_RST);
    rd(4'hc, 8'h00);
    // Clock output stays off while pins are switched
    for (int i = 0; i < 32; i++) pins({i[4:3], 4'h0, i[2:1]}, i[0]);
    wb(1'b1, `CPC_OFF_PIN_MODE, 8'h00, 4'he);
    // Select bits and pin enable stand before any clock is started
    rd(`CPC_OFF_PIN_MODE, 8'hc3);
    spi_mode <= 1'b0;
    wb(1'b1, `CPC_OFF_PIN_MODE, 8'h01);
    clk_rate(3'h0, divs[0]);
    for (int c = 1; c < 4; c++) clk_rate(3'(c), divs[c]);
    clk_rate(3'h4, divs[4]);
    clk_rate(3'h5, 1);
    wb(1'b1, `CPC_OFF_CLK_CTL, 8'h00);
    quiet();
    clk_rate(3'h3, 2);
    rd(`CPC_OFF_STATUS, 8'h07);
    wb(1'b1, `CPC_OFF_PIN_MODE, 8'h00);
    quiet();
    close_out();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule // cpc_top_test
